/* hw/clmo_cache_maint.v */
// cache line maintenance operations: data-cache tag write and instruction-cache invalidate
// Notes on behaviour
// [RQ1] flush of dirty line writes each valid word
// [RQ2] clear tag; with match flag only if equal
// [RQ3] external flag issues flush or invalidate request
// [RQ4] eight-word line address masks low five bits
// [RQ5] user mode with mmu raises cause 00111
// [RQ6] address-matched clear completes in two cycles
// [RQ7] invalidate takes two or three cycles
// [RQ8] flush takes two plus writeback cycles
// [RQ9] data ops ignore data-cache enable bit
// [RQ10] data op address is always physical
// [RQ11] instruction invalidate zeroes tag, ignores operand two
// [RQ12] instruction index shifts by four or five
// [RQ13] instruction invalidate ignores its enable bit
// [RQ14] instruction address virtual only in mode three
// [RQ15] writeback: address is sum, external ignored
// [RQ16] write-through: address is first operand only
// [RQ17] external flag needs coherent interconnect setting
// [RQ18] four-word line shifts and masks four bits
// [RQ19] exception leaves caches and memory unchanged
`timescale 1ns/1ps
`include "clmo_defs.vh"

module clmo_cache_maint #(
    parameter WRITEBACK_POLICY_PARAM   = 1,
    parameter MEMORY_MGMT_CONFIG_PARAM = 0,
    parameter DLINE_WORDS_PARAM        = 8,
    parameter ILINE_WORDS_PARAM        = 8,
    parameter DCACHE_LINES_LOG2        = 6,
    parameter ICACHE_LINES_LOG2        = 6,
    parameter AREA_OPTIMIZED           = 0,
    parameter INTERCONNECT_SEL         = 3
) (
    input  wire        i_sys_clk,
    input  wire        i_rst,
    // operation request from the pipeline
    input  wire        i_op_valid,
    input  wire        i_op_is_icache,
    input  wire        i_flag_flush,
    input  wire        i_flag_match,
    input  wire        i_flag_ext,
    input  wire [31:0] i_opnd_a,
    input  wire [31:0] i_opnd_b,
    input  wire        i_user_mode_flag,
    input  wire        i_virtual_mode,
    input  wire        i_data_cache_enable_flag,
    input  wire        i_instr_cache_enable_flag,
    output wire        o_op_ready,
    output reg         o_op_done,
    output reg         o_priv_exc,
    output reg  [4:0]  o_exception_cause_code,
    // data cache line seed: loads a line with tag, dirty and valid bits
    input  wire        i_dline_fill,
    input  wire [31:0] i_dline_fill_addr,
    input  wire [7:0]  i_dline_fill_valid,
    input  wire        i_dline_fill_dirty,
    input  wire [31:0] i_dline_fill_word,
    // tag status lookup
    input  wire [31:0] i_probe_addr,
    output reg         o_dline_tag_valid,
    output reg         o_iline_tag_valid,
    // memory write port
    output reg         o_mem_wr,
    output reg  [31:0] o_mem_addr,
    output reg  [31:0] o_mem_data,
    input  wire        i_mem_ready,
    // external coherent cache request
    output reg         o_ext_req,
    output reg         o_ext_flush,
    output reg  [31:0] o_ext_addr,
    input  wire        i_ext_ready,
    // instruction address kind, high when virtual
    output reg         o_iaddr_virtual
);

    localparam DLINES = 1 << DCACHE_LINES_LOG2;
    localparam ILINES = 1 << ICACHE_LINES_LOG2;

    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_WAIT  = 6'h02;
    localparam [5:0] ST_WB    = 6'h04;
    localparam [5:0] ST_EXT   = 6'h08;
    localparam [5:0] ST_TAG   = 6'h10;
    localparam [5:0] ST_DONE  = 6'h20;

    // --------------------------------------------------------------------
    // helper functions
    // --------------------------------------------------------------------
    // line address by line length
    function [31:0] line_base;
        input [31:0] addr;
        input integer words;
        begin
            if (words == 8)
                line_base = addr & `CLMO_LINE8_MASK; // RQ4
            else
                line_base = addr & `CLMO_LINE4_MASK; // RQ18
        end
    endfunction

    // line index by line length, masked to line count
    function [31:0] line_index;
        input [31:0] addr;
        input integer words;
        input integer lg;
        begin
            if (words == 8)
                line_index = (addr >> `CLMO_LINE8_SHIFT) & ((32'h1 << lg) - 32'h1);
            else
                line_index = (addr >> `CLMO_LINE4_SHIFT) & ((32'h1 << lg) - 32'h1);
        end
    endfunction

    // --------------------------------------------------------------------
    // storage
    // --------------------------------------------------------------------
    reg [31:0] dtag_q   [0:DLINES-1];
    reg        dvld_q   [0:DLINES-1];
    reg        ddirty_q [0:DLINES-1];
    reg [7:0]  dwv_q    [0:DLINES-1];
    reg [31:0] ddata_q  [0:DLINES*8-1];
    reg        ivld_q   [0:ILINES-1];

    reg [5:0]  state_q;
    reg [31:0] addr_q;
    reg [31:0] base_q;
    reg [31:0] didx_q;
    reg        flush_q;
    reg        match_q;
    reg        ext_q;
    reg        icache_q;
    reg [2:0]  wcnt_q;
    reg [1:0]  cyc_q;

    wire priv_fail = (MEMORY_MGMT_CONFIG_PARAM >= 1) && i_user_mode_flag; // RQ5
    // sum for writeback, first operand only for write-through
    wire [31:0] op_addr = (WRITEBACK_POLICY_PARAM == 1) ? (i_opnd_a + i_opnd_b) // RQ15
                                                         : i_opnd_a;          // RQ16
    // external flag honoured only when write-through and coherent link
    wire ext_eff = i_flag_ext && (WRITEBACK_POLICY_PARAM == 0) // RQ15
                   && (INTERCONNECT_SEL == `CLMO_IF_COHERENT); // RQ17
    wire [31:0] d_idx_w = line_index(op_addr, DLINE_WORDS_PARAM, DCACHE_LINES_LOG2);
    wire [31:0] i_idx_w = line_index(i_opnd_a, ILINE_WORDS_PARAM, ICACHE_LINES_LOG2); // RQ11 RQ12
    wire [31:0] p_d_idx = line_index(i_probe_addr, DLINE_WORDS_PARAM, DCACHE_LINES_LOG2);
    wire [31:0] p_i_idx = line_index(i_probe_addr, ILINE_WORDS_PARAM, ICACHE_LINES_LOG2);
    wire [31:0] f_idx   = line_index(i_dline_fill_addr, DLINE_WORDS_PARAM, DCACHE_LINES_LOG2);
    wire [31:0] wptr    = {didx_q[28:0], wcnt_q};

    assign o_op_ready = (state_q == ST_IDLE);

    // --------------------------------------------------------------------
    // operation sequencer; enable bits never gate it
    // --------------------------------------------------------------------
    integer k;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q  <= ST_IDLE;
            addr_q   <= 32'h0;
            base_q   <= 32'h0;
            didx_q   <= 32'h0;
            flush_q  <= 1'b0;
            match_q  <= 1'b0;
            ext_q    <= 1'b0;
            icache_q <= 1'b0;
            wcnt_q   <= 3'h0;
            cyc_q    <= 2'h0;
            o_op_done <= 1'b0;
            o_priv_exc <= 1'b0;
            o_exception_cause_code <= 5'h00;
            o_mem_wr <= 1'b0;
            o_mem_addr <= 32'h0;
            o_mem_data <= 32'h0;
            o_ext_req <= 1'b0;
            o_ext_flush <= 1'b0;
            o_ext_addr <= 32'h0;
            o_iaddr_virtual <= 1'b0;
            for (k = 0; k < DLINES; k = k + 1) begin
                dvld_q[k]   <= 1'b0;
                ddirty_q[k] <= 1'b0;
            end
            for (k = 0; k < ILINES; k = k + 1) begin
                ivld_q[k] <= 1'b0;
            end
        end else begin
            o_op_done  <= 1'b0;
            o_priv_exc <= 1'b0;
            if (i_dline_fill && state_q == ST_IDLE) begin
                dtag_q[f_idx]   <= line_base(i_dline_fill_addr, DLINE_WORDS_PARAM);
                dvld_q[f_idx]   <= 1'b1;
                ddirty_q[f_idx] <= i_dline_fill_dirty;
                dwv_q[f_idx]    <= i_dline_fill_valid;
                for (k = 0; k < 8; k = k + 1) begin
                    ddata_q[f_idx * 8 + k] <= i_dline_fill_word + k;
                end
            end
            case (state_q)
                ST_IDLE: begin
                    if (i_op_valid) begin
                        if (priv_fail) begin
                            // nothing else touched on exception
                            o_priv_exc <= 1'b1; // RQ19
                            o_exception_cause_code <= `CLMO_EC_PRIV; // RQ5
                            o_op_done <= 1'b1;
                        end else begin
                            addr_q   <= op_addr; // RQ10
                            base_q   <= line_base(op_addr, DLINE_WORDS_PARAM);
                            didx_q   <= d_idx_w;
                            flush_q  <= i_flag_flush;
                            match_q  <= i_flag_match;
                            ext_q    <= ext_eff;
                            icache_q <= i_op_is_icache;
                            wcnt_q   <= 3'h0;
                            cyc_q    <= 2'h0;
                            if (i_op_is_icache) begin
                                ivld_q[i_idx_w] <= 1'b0; // RQ11 RQ13
                                o_iaddr_virtual <= (MEMORY_MGMT_CONFIG_PARAM ==
                                    `CLMO_MMU_VIRTUAL) && i_virtual_mode; // RQ14
                                state_q <= ST_DONE;
                            end else if (ext_eff) begin
                                state_q <= ST_EXT;
                            end else if (i_flag_flush && dvld_q[d_idx_w[DCACHE_LINES_LOG2-1:0]]
                                         && ddirty_q[d_idx_w[DCACHE_LINES_LOG2-1:0]]) begin
                                state_q <= ST_WB; // RQ1 RQ8
                            end else if (!i_flag_flush && !i_flag_match
                                         && AREA_OPTIMIZED == 0) begin
                                state_q <= ST_WAIT; // RQ7
                            end else begin
                                state_q <= ST_TAG; // RQ6 RQ9
                            end
                        end
                    end
                end
                ST_WAIT: begin
                    state_q <= ST_TAG; // RQ7
                end
                ST_WB: begin
                    // one valid word per beat, skip invalid ones
                    if (o_mem_wr && !i_mem_ready) begin
                        state_q <= ST_WB;
                    end else if (dwv_q[didx_q][wcnt_q] && !o_mem_wr) begin
                        o_mem_wr   <= 1'b1; // RQ1
                        o_mem_addr <= base_q + {27'h0, wcnt_q, 2'h0}; // RQ1
                        o_mem_data <= ddata_q[wptr];
                    end else begin
                        o_mem_wr <= 1'b0;
                        if (wcnt_q == DLINE_WORDS_PARAM - 1) begin
                            ddirty_q[didx_q] <= 1'b0;
                            state_q <= ST_TAG; // RQ8
                        end else begin
                            wcnt_q <= wcnt_q + 3'h1;
                        end
                    end
                end
                ST_EXT: begin
                    o_ext_req   <= 1'b1; // RQ3
                    o_ext_flush <= flush_q; // RQ3
                    o_ext_addr  <= addr_q;
                    if (o_ext_req && i_ext_ready) begin
                        o_ext_req <= 1'b0;
                        o_op_done <= 1'b1;
                        state_q   <= ST_IDLE;
                    end
                end
                ST_TAG: begin
                    if (!match_q || dtag_q[didx_q] == base_q) begin
                        dvld_q[didx_q]   <= 1'b0; // RQ2
                        ddirty_q[didx_q] <= 1'b0; // RQ2
                    end
                    o_op_done <= 1'b1;
                    state_q   <= ST_IDLE;
                end
                ST_DONE: begin
                    o_op_done <= 1'b1;
                    state_q   <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------------
    // tag status lookup
    // --------------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_dline_tag_valid <= 1'b0;
            o_iline_tag_valid <= 1'b0;
        end else begin
            o_dline_tag_valid <= dvld_q[p_d_idx] && dtag_q[p_d_idx] ==
                                 line_base(i_probe_addr, DLINE_WORDS_PARAM);
            o_iline_tag_valid <= ivld_q[p_i_idx];
        end
    end

endmodule // clmo_cache_maint

/* hw/clmo_defs.vh */
// constants for the cache line maintenance block
`ifndef CLMO_DEFS_VH
`define CLMO_DEFS_VH
// --------------------------------------------------------------------
// line geometry
// --------------------------------------------------------------------
`define CLMO_LINE4_SHIFT     4
`define CLMO_LINE8_SHIFT     5
`define CLMO_LINE4_MASK      32'hfffffff0
`define CLMO_LINE8_MASK      32'hffffffe0
`define CLMO_WORD_BYTES      32'h00000004
// --------------------------------------------------------------------
// exception, timing and configuration selectors
// --------------------------------------------------------------------
`define CLMO_EC_PRIV         5'h07
`define CLMO_LAT_CLEAR       2
`define CLMO_LAT_INV_AREA    2
`define CLMO_LAT_INV_FAST    3
`define CLMO_LAT_FLUSH_BASE  2
`define CLMO_IF_COHERENT     3
`define CLMO_MMU_VIRTUAL     3
`endif

/* test/clmo_cache_maint_sva.sv */
// assertions on the ports of the cache line maintenance block
`timescale 1ns/1ps
module clmo_cache_maint_sva #(
    parameter WRITEBACK_POLICY_PARAM   = 1,
    parameter MEMORY_MGMT_CONFIG_PARAM = 0,
    parameter AREA_OPTIMIZED           = 0
) (
    input wire        i_sys_clk,
    input wire        i_rst,
    input wire        i_op_valid,
    input wire        i_op_is_icache,
    input wire        i_flag_flush,
    input wire        i_flag_match,
    input wire        i_user_mode_flag,
    input wire        o_op_ready,
    input wire        o_op_done,
    input wire        o_priv_exc,
    input wire [4:0]  o_exception_cause_code,
    input wire        o_mem_wr,
    input wire [31:0] o_mem_addr,
    input wire        i_mem_ready,
    input wire        o_ext_req,
    input wire        o_iaddr_virtual
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // accepted request, refused by privilege, or a local data operation
    wire take = i_op_valid && o_op_ready;
    wire priv = take && i_user_mode_flag && (MEMORY_MGMT_CONFIG_PARAM >= 1);
    wire dop  = take && !i_op_is_icache && !priv && (WRITEBACK_POLICY_PARAM == 1);
    exc_code_a: assert property (o_priv_exc |-> o_exception_cause_code == 5'h07)
        else $error("wrong cause code");
    exc_quiet_a: assert property (priv |=> o_priv_exc && o_op_done && !o_mem_wr)
        else $error("privilege refusal wrong");
    clear_lat_a: assert property (dop && i_flag_match && !i_flag_flush
        |=> !o_op_done ##1 o_op_done) else $error("clear latency wrong");
    inv_lat_a: assert property (dop && !i_flag_match && !i_flag_flush
        && AREA_OPTIMIZED == 0 |=> !o_op_done [*2] ##1 o_op_done) else $error("inv latency");
    no_discard_a: assert property (dop && !i_flag_flush |=> !o_mem_wr [*3])
        else $error("write without flush");
    wic_lat_a: assert property (take && i_op_is_icache && !priv
        |=> !o_op_done ##1 o_op_done) else $error("icache latency wrong");
    wr_hold_a: assert property (o_mem_wr && !i_mem_ready |=> o_mem_wr && $stable(o_mem_addr))
        else $error("write dropped early");
    word_align_a: assert property (o_mem_wr |-> o_mem_addr[1:0] == 2'h0)
        else $error("unaligned write");
    ext_off_a: assert property (!(WRITEBACK_POLICY_PARAM == 1 && o_ext_req))
        else $error("external request in writeback");
    iaddr_phys_a: assert property (MEMORY_MGMT_CONFIG_PARAM != 3 |-> !o_iaddr_virtual)
        else $error("virtual icache address");
endmodule // clmo_cache_maint_sva
bind clmo_cache_maint clmo_cache_maint_sva #(
    .WRITEBACK_POLICY_PARAM(WRITEBACK_POLICY_PARAM),
    .MEMORY_MGMT_CONFIG_PARAM(MEMORY_MGMT_CONFIG_PARAM),
    .AREA_OPTIMIZED(AREA_OPTIMIZED)
) chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_op_valid(i_op_valid),
    .i_op_is_icache(i_op_is_icache), .i_flag_flush(i_flag_flush), .i_flag_match(i_flag_match),
    .i_user_mode_flag(i_user_mode_flag), .o_op_ready(o_op_ready), .o_op_done(o_op_done),
    .o_priv_exc(o_priv_exc), .o_exception_cause_code(o_exception_cause_code),
    .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .i_mem_ready(i_mem_ready),
    .o_ext_req(o_ext_req), .o_iaddr_virtual(o_iaddr_virtual));

/* test/clmo_mem_model.sv */
// memory and external cache responder for the maintenance block
`timescale 1ns/1ps
module clmo_mem_model (
    input  wire        i_sys_clk,
    input  wire        i_rst,
    input  wire [3:0]  i_wait,
    input  wire        i_mem_wr,
    input  wire [31:0] i_mem_addr,
    input  wire [31:0] i_mem_data,
    output reg         o_mem_ready,
    input  wire        i_ext_req,
    output reg         o_ext_ready
);
    reg [3:0]  wait_q = 4'h0;
    reg [31:0] addr_log [0:15];
    reg [31:0] data_log [0:15];
    integer    wr_count = 0;
    // accept a held write after i_wait cycles and log it
    always @(posedge i_sys_clk) begin
        o_mem_ready <= i_mem_wr && !o_mem_ready && !i_rst && wait_q == i_wait;
        o_ext_ready <= i_ext_req && !o_ext_ready && !i_rst;
        if (i_rst || !i_mem_wr || o_mem_ready) begin
            wait_q <= 4'h0;
        end else if (wait_q != i_wait) begin
            wait_q <= wait_q + 4'h1;
        end
        if (i_mem_wr && o_mem_ready && !i_rst) begin
            addr_log[wr_count[3:0]] <= i_mem_addr;
            data_log[wr_count[3:0]] <= i_mem_data;
            wr_count <= wr_count + 1;
        end
    end
endmodule // clmo_mem_model

/* test/clmo_cache_maint_bench.sv */
// self-checking bench for the cache line maintenance block
`timescale 1ns/1ps
module clmo_cache_maint_bench;
    reg        clk = 1'b0, rst = 1'b1, valid = 1'b0, ic = 1'b0, ff = 1'b0, fm = 1'b0;
    reg        fe = 1'b0, um = 1'b0, vm = 1'b0, den = 1'b0, ien = 1'b0, fill = 1'b0;
    reg        fdirty = 1'b0;
    reg [7:0]  fvalid = 8'h00;
    reg [3:0]  mwait = 4'h0;
    reg [31:0] a = 0, b = 0, faddr = 0, fword = 0, probe = 0;
    wire       ready, done, exc, dtag, itag, mwr, mrdy, ereq, eflush, erdy, ivirt;
    wire [4:0] cause;
    wire [31:0] maddr, mdata, eaddr;
    reg        valid2 = 1'b0, sel = 1'b0;
    wire       done2, dtag2, mwr2, mrdy2, ereq2, eflush2, erdy2, ivirt2;
    wire [31:0] maddr2, mdata2, eaddr2;
    integer    fail_count = 0, checks = 0, cycles = 0, lat, i, n0;
    clmo_cache_maint #(.MEMORY_MGMT_CONFIG_PARAM(1)) DUT (.i_sys_clk(clk), .i_rst(rst),
        .i_op_valid(valid), .i_op_is_icache(ic), .i_flag_flush(ff), .i_flag_match(fm),
        .i_flag_ext(fe), .i_opnd_a(a), .i_opnd_b(b), .i_user_mode_flag(um),
        .i_virtual_mode(vm), .i_data_cache_enable_flag(den), .i_instr_cache_enable_flag(ien),
        .o_op_ready(ready), .o_op_done(done), .o_priv_exc(exc), .o_exception_cause_code(cause),
        .i_dline_fill(fill), .i_dline_fill_addr(faddr), .i_dline_fill_valid(fvalid),
        .i_dline_fill_dirty(fdirty), .i_dline_fill_word(fword), .i_probe_addr(probe),
        .o_dline_tag_valid(dtag), .o_iline_tag_valid(itag), .o_mem_wr(mwr),
        .o_mem_addr(maddr), .o_mem_data(mdata), .i_mem_ready(mrdy), .o_ext_req(ereq),
        .o_ext_flush(eflush), .o_ext_addr(eaddr), .i_ext_ready(erdy), .o_iaddr_virtual(ivirt));
    clmo_mem_model mem (.i_sys_clk(clk), .i_rst(rst), .i_wait(mwait), .i_mem_wr(mwr),
        .i_mem_addr(maddr), .i_mem_data(mdata), .o_mem_ready(mrdy), .i_ext_req(ereq),
        .o_ext_ready(erdy));
    // second instance: write-through, four-word lines, coherent link, virtual mmu
    clmo_cache_maint #(.WRITEBACK_POLICY_PARAM(0), .MEMORY_MGMT_CONFIG_PARAM(3),
        .DLINE_WORDS_PARAM(4), .AREA_OPTIMIZED(1)) DUT2 (.i_sys_clk(clk), .i_rst(rst),
        .i_op_valid(valid2), .i_op_is_icache(ic), .i_flag_flush(ff), .i_flag_match(fm),
        .i_flag_ext(fe), .i_opnd_a(a), .i_opnd_b(b), .i_user_mode_flag(um),
        .i_virtual_mode(vm), .i_data_cache_enable_flag(den), .i_instr_cache_enable_flag(ien),
        .o_op_ready(), .o_op_done(done2), .o_priv_exc(), .o_exception_cause_code(),
        .i_dline_fill(fill), .i_dline_fill_addr(faddr), .i_dline_fill_valid(fvalid),
        .i_dline_fill_dirty(fdirty), .i_dline_fill_word(fword), .i_probe_addr(probe),
        .o_dline_tag_valid(dtag2), .o_iline_tag_valid(), .o_mem_wr(mwr2),
        .o_mem_addr(maddr2), .o_mem_data(mdata2), .i_mem_ready(mrdy2), .o_ext_req(ereq2),
        .o_ext_flush(eflush2), .o_ext_addr(eaddr2), .i_ext_ready(erdy2),
        .o_iaddr_virtual(ivirt2));
    clmo_mem_model mem2 (.i_sys_clk(clk), .i_rst(rst), .i_wait(mwait), .i_mem_wr(mwr2),
        .i_mem_addr(maddr2), .i_mem_data(mdata2), .o_mem_ready(mrdy2), .i_ext_req(ereq2),
        .o_ext_ready(erdy2));
    // clock and cycle ceiling
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task print_verdict;
        begin
            $display("checks %0d, mismatches %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task seed(input [31:0] ad, input [7:0] vmask, input dy);
        begin
            @(posedge clk);
            fill <= 1'b1;
            faddr <= ad;
            fvalid <= vmask;
            fdirty <= dy;
            fword <= ad ^ 32'h5a5a0000;
            @(posedge clk);
            fill <= 1'b0;
        end
    endtask
    task op(input c, input f, input m, input e, input u, input [31:0] x, input [31:0] y);
        begin
            n0 = mem.wr_count;
            @(posedge clk);
            valid <= !sel;
            valid2 <= sel;
            ic <= c;
            ff <= f;
            fm <= m;
            fe <= e;
            um <= u;
            a <= x;
            b <= y;
            @(posedge clk);
            valid <= 1'b0;
            valid2 <= 1'b0;
            // the taking edge counts as the first cycle
            #1 lat = 1;
            while ((sel ? done2 : done) !== 1'b1 && lat < 40) begin
                @(posedge clk);
                #1 lat = lat + 1;
            end
            if ((sel ? done2 : done) !== 1'b1) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: operation never finished", $time);
            end
        end
    endtask
    task probe_chk(input [31:0] ad, input exp);
        begin
            @(posedge clk);
            probe <= ad;
            repeat (2) @(posedge clk);
            #1 check(sel ? dtag2 : dtag, exp);
        end
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        mwait <= 4'h2;
        seed(32'h00001040, 8'ha5, 1'b1);
        op(0, 1, 0, 1, 0, 32'h00001000, 32'h00000045);
        check(mem.wr_count - n0, 4);
        for (i = 0; i < 4; i = i + 1) begin
            check(mem.addr_log[i], 32'h1040 + 4 * ((16'h7520 >> (4 * i)) & 16'hf));
            check(mem.data_log[i], 32'h5a5a1040 + ((16'h7520 >> (4 * i)) & 16'hf));
        end
        probe_chk(32'h00001040, 1'b0);
        seed(32'h00001060, 8'hff, 1'b0);
        op(0, 1, 0, 0, 0, 32'h00001060, 32'h0);
        check(lat, 2);
        check(mem.wr_count - n0, 0);
        seed(32'h00002020, 8'hff, 1'b1);
        op(0, 0, 1, 0, 0, 32'h00002800, 32'h00000020);
        check(lat, 2);
        check(ready, 1'b1);
        probe_chk(32'h00002020, 1'b1);
        op(0, 0, 1, 0, 0, 32'h00002020, 32'h0000001f);
        check(mem.wr_count - n0, 0);
        probe_chk(32'h00002020, 1'b0);
        @(posedge clk);
        den <= 1'b1;
        seed(32'h00003000, 8'hff, 1'b1);
        op(0, 0, 0, 1, 0, 32'h00003000, 32'h00000004);
        check(lat, 3);
        check(eaddr, 32'h0);
        check({ereq, eflush}, 2'h0);
        probe_chk(32'h00003000, 1'b0);
        seed(32'h00004000, 8'hff, 1'b1);
        op(0, 1, 0, 0, 1, 32'h00004000, 32'h0);
        check({exc, cause}, 6'h27);
        check(lat, 1);
        check(mem.wr_count - n0, 0);
        probe_chk(32'h00004000, 1'b1);
        @(posedge clk);
        vm <= 1'b1;
        ien <= 1'b1;
        op(1, 0, 0, 0, 0, 32'h00000100, 32'hffffffff);
        check(lat, 2);
        check(ivirt, 0);
        check(itag, 0);
        sel = 1'b1;
        op(1, 0, 0, 0, 0, 32'h00000100, 32'h0);
        check(ivirt2, 1'b1);
        seed(32'h00005010, 8'h0f, 1'b1);
        op(0, 0, 0, 0, 0, 32'h00005018, 32'h00000100);
        check(lat, 2);
        probe_chk(32'h00005010, 1'b0);
        op(0, 1, 0, 1, 0, 32'h00006000, 32'h00000040);
        check(eflush2, 1'b1);
        check(eaddr2, 32'h00006000);
        op(0, 0, 0, 1, 0, 32'h00006100, 32'h0);
        check(eflush2, 1'b0);
        check(eaddr2, 32'h00006100);
        print_verdict;
    end
endmodule // clmo_cache_maint_bench
